// File: dv/sensor_engine_model.sv
// behavioural model of the sensing engine that finishes the bank's pending commands
`default_nettype none
module sensor_engine_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_watchdog_reset,
    input  wire logic       i_retune_all,
    input  wire logic       i_refresh_all_avg,
    output logic            o_watchdog_done,
    output logic            o_tuning_active,
    output logic            o_tuning_done,
    output logic            o_refresh_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;

    // one shared timer; i_delay picks a prompt or a slow engine
    always @(negedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt <= 4'h0;
            o_watchdog_done <= 1'h0;
            o_tuning_done <= 1'h0;
            o_refresh_done <= 1'h0;
        end else begin
            o_watchdog_done <= 1'h0;
            o_tuning_done <= 1'h0;
            o_refresh_done <= 1'h0;
            if (!(i_watchdog_reset | i_retune_all | i_refresh_all_avg)) begin
                wait_cnt <= 4'h0;
            end else if (wait_cnt < i_delay) begin
                wait_cnt <= wait_cnt + 4'h1;
            end else begin
                o_watchdog_done <= i_watchdog_reset;
                o_tuning_done <= i_retune_all;
                o_refresh_done <= i_refresh_all_avg;
                wait_cnt <= 4'h0;
            end
        end
    end

    // tuning runs exactly while its restart is pending
    assign o_tuning_active = i_retune_all;
endmodule
`default_nettype wire

// File: dv/sensor_system_control_regs_test.sv
// self-checking bench of the system control register bank
`default_nettype none
`include "sensor_ctrl_params.svh"
module sensor_system_control_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic [15:0] reading = 16'h0000;
    logic [15:0] target = 16'h0000;
    logic        rvalid = 1'h0;
    logic [15:0] traw = 16'h0000;
    logic        tvalid = 1'h0;
    logic [3:0]  delay = 4'h6;
    logic [7:0]  rdata;
    logic        wd_done, tun_act, tun_done, ref_done, wd_rst, rst_evt, ev_mode, slow_osc;
    logic        win_sel, comm_ok, retune_all, retune_ch, refresh, temp_valid;
    logic [25:0] temp;
    int          fail_count = 0;
    int          samples_checked = 0;

    // 125 MHz
    always #4 mclk = ~mclk;

    sensor_system_control_regs u_dut (.i_mclk(mclk), .i_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_watchdog_done(wd_done), .i_tuning_active(tun_act), .i_tuning_done(tun_done),
        .i_refresh_done(ref_done), .i_reading(reading), .i_target(target), .i_reading_valid(rvalid),
        .i_temp_raw(traw), .i_temp_raw_valid(tvalid), .o_watchdog_reset(wd_rst),
        .o_reset_event(rst_evt), .o_event_mode(ev_mode), .o_slow_oscillator_select(slow_osc),
        .o_retune_window_select(win_sel), .o_comm_allowed(comm_ok), .o_retune_all(retune_all),
        .o_retune_channel(retune_ch), .o_refresh_all_avg(refresh), .o_temp(temp),
        .o_temp_valid(temp_valid));

    sensor_engine_model u_engine (.i_mclk(mclk), .i_rst(rst), .i_delay(delay),
        .i_watchdog_reset(wd_rst), .i_retune_all(retune_all), .i_refresh_all_avg(refresh),
        .o_watchdog_done(wd_done), .o_tuning_active(tun_act), .o_tuning_done(tun_done),
        .o_refresh_done(ref_done));

    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // all access tasks start and end at a falling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'h1;
        @(negedge mclk);
        wr = 1'h0;
        @(negedge mclk);
    endtask

    // waits a spare cycle so the registered read data has surely landed
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'h1;
        @(negedge mclk);
        rd = 1'h0;
        @(negedge mclk);
        chk(rdata, exp);
    endtask

    task automatic temp_chk(input logic [15:0] raw, input logic [25:0] exp);
        traw = raw;
        tvalid = 1'h1;
        @(negedge mclk);
        tvalid = 1'h0;
        chk(temp_valid, 1'h1);
        chk(temp, exp);
        @(negedge mclk);
        chk(temp_valid, 1'h0);
    endtask

    // probes just inside and just outside both edges of the band
    task automatic win_set(input logic narrow);
        logic [15:0] band;
        band = 16'h0320 >> (narrow ? 4 : 3);
        target = 16'h0320;
        for (int i = 0; i < 4; i++) begin
            reading = i[1] ? 16'h0320 - band - 16'(!i[0]) : 16'h0320 + band + 16'(!i[0]);
            rvalid = 1'h1;
            @(negedge mclk);
            rvalid = 1'h0;
            chk(retune_ch, !i[0]);
        end
    endtask

    // bounded wait for the engine to finish every pending command
    task automatic wait_idle;
        int n;
        for (n = 0; n < 40 && (wd_rst | retune_all | refresh); n++) @(negedge mclk);
        if (n == 40) begin
            fail_count++;
            $display("Error at %0t: command never finished", $time);
        end
        @(negedge mclk);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #40000;
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'h0;
        chk(rst_evt, 1'h1);
        chk(comm_ok, 1'h1);
        rd_reg(`SC_ADDR_SYS_CTRL, `SC_SYS_RESET);
        rd_reg(8'h55, `SC_READ_UNMAPPED);
        for (int i = 0; i < 3; i++) rd_reg(8'hC2 + 8'(i), `SC_CAL_RESET);
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h48);
        chk(rst_evt, 1'h0);
        rd_reg(`SC_ADDR_SYS_CTRL, 8'h08);
        // never all-ones in multiplier or divider
        wr_reg(`SC_ADDR_TEMP_MUL, 8'h01);
        wr_reg(`SC_ADDR_TEMP_DIV, 8'h00);
        wr_reg(`SC_ADDR_TEMP_OFF, 8'h05);
        temp_chk(16'h0064, 26'h0000CD);
        wr_reg(`SC_ADDR_TEMP_MUL, 8'hFE);
        wr_reg(`SC_ADDR_TEMP_DIV, 8'h03);
        wr_reg(`SC_ADDR_TEMP_OFF, 8'hFF);
        temp_chk(16'h03E8, 26'h00FA05);
        rd_reg(`SC_ADDR_TEMP_MUL, 8'hFE);
        rd_reg(`SC_ADDR_TEMP_DIV, 8'h03);
        rd_reg(`SC_ADDR_TEMP_OFF, 8'hFF);
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h3C);
        chk({ev_mode, slow_osc, win_sel}, 3'h7);
        rd_reg(`SC_ADDR_SYS_CTRL, 8'h3C);
        win_set(1'h1);
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h00);
        chk({ev_mode, slow_osc, win_sel}, 3'h0);
        win_set(1'h0);
        // retune in a later window than the oscillator change, talk off, slow engine
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h02);
        chk(retune_all, 1'h1);
        rd_reg(`SC_ADDR_SYS_CTRL, 8'h02);
        chk(comm_ok, 1'h0);
        wait_idle();
        chk(comm_ok, 1'h1);
        rd_reg(`SC_ADDR_SYS_CTRL, 8'h00);
        // talk on: traffic allowed while tuning, prompt engine
        delay = 4'h1;
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h0A);
        chk(comm_ok, 1'h1);
        wait_idle();
        delay = 4'h3;
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h09);
        chk(refresh, 1'h1);
        wait_idle();
        rd_reg(`SC_ADDR_SYS_CTRL, 8'h08);
        // soft reset must restore config and calibration defaults
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h3C);
        wr_reg(`SC_ADDR_SYS_CTRL, 8'hBC);
        chk(wd_rst, 1'h1);
        wait_idle();
        chk(rst_evt, 1'h1);
        rd_reg(`SC_ADDR_SYS_CTRL, `SC_SYS_RESET);
        rd_reg(`SC_ADDR_TEMP_MUL, `SC_CAL_RESET);
        wr_reg(`SC_ADDR_SYS_CTRL, 8'h48);
        chk(rst_evt, 1'h0);
        complete_run();
    end
endmodule
`default_nettype wire

// File: hdl/sensor_ctrl_params.svh
// register offsets, field positions and reset values of the system control register bank
`ifndef SENSOR_CTRL_PARAMS_SVH
`define SENSOR_CTRL_PARAMS_SVH

`define SC_ADDR_TEMP_MUL     8'hC2
`define SC_ADDR_TEMP_DIV     8'hC3
`define SC_ADDR_TEMP_OFF     8'hC4
`define SC_ADDR_SYS_CTRL     8'hD0

`define SC_CAL_RESET         8'h00
`define SC_SYS_RESET         8'h08
`define SC_READ_UNMAPPED     8'h00

`define SC_BIT_SOFT_RESET    7
`define SC_BIT_ACK_RESET     6
`define SC_BIT_EVENT_MODE    5
`define SC_BIT_SLOW_OSC      4
`define SC_BIT_TALK_TUNING   3
`define SC_BIT_WINDOW_SEL    2
`define SC_BIT_RETUNE_ALL    1
`define SC_BIT_REFRESH_AVG   0

`define SC_WINDOW_WIDE_SHIFT   3
`define SC_WINDOW_NARROW_SHIFT 4

`endif

// File: hdl/sensor_ctrl_pkg.sv
// types shared by the system control register bank and its temperature unit
`default_nettype none
package sensor_ctrl_pkg;

    // stored configuration bits of the system control register
    typedef struct packed {
        logic event_mode;
        logic slow_oscillator_select;
        logic talk_during_tuning;
        logic retune_window_select;
    } sys_cfg_t;

    // set-only command bits that stay pending until their action or a watchdog reset finishes
    typedef struct packed {
        logic soft_reset;
        logic retune_all;
        logic refresh_avg;
    } cmd_pend_t;

    // temperature calibration constants as stored
    typedef struct packed {
        logic [7:0] multiplier;
        logic [7:0] divider;
        logic [7:0] offset;
    } temp_cal_t;

endpackage
`default_nettype wire

// File: hdl/sensor_system_control_regs.sv
// system control and temperature calibration register bank of the sensing device
// Function
// - offset field used directly, 0 to 255
// - multiplier applied as stored value plus one
// - divider applied as stored value plus one
// - soft reset bit triggers watchdog reset, self-clears
// - reset event signalled until host acknowledges
// - report style: zero streaming, one event
// - talk-during-tuning gates communication while tuning
// - retune channel outside 1/8 or 1/16 window
// - retune-all restarts tuning, clears when complete
// - refresh reloads all averages, clears when done
`default_nettype none
`include "sensor_ctrl_params.svh"
module sensor_system_control_regs #(
    parameter int RAW_W = 16,
    parameter int RD_W  = 16
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic [7:0]         i_reg_addr,
    input  wire logic [7:0]         i_reg_wdata,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    output var  logic [7:0]         o_reg_rdata,
    input  wire logic               i_watchdog_done,
    input  wire logic               i_tuning_active,
    input  wire logic               i_tuning_done,
    input  wire logic               i_refresh_done,
    input  wire logic [RD_W-1:0]    i_reading,
    input  wire logic [RD_W-1:0]    i_target,
    input  wire logic               i_reading_valid,
    input  wire logic [RAW_W-1:0]   i_temp_raw,
    input  wire logic               i_temp_raw_valid,
    output var  logic               o_watchdog_reset,
    output var  logic               o_reset_event,
    output var  logic               o_event_mode,
    output var  logic               o_slow_oscillator_select,
    output var  logic               o_retune_window_select,
    output var  logic               o_comm_allowed,
    output var  logic               o_retune_all,
    output var  logic               o_retune_channel,
    output var  logic               o_refresh_all_avg,
    output var  logic [RAW_W+9:0]   o_temp,
    output var  logic               o_temp_valid
);
    sensor_ctrl_pkg::sys_cfg_t  cfg;
    sensor_ctrl_pkg::sys_cfg_t  next_cfg;
    sensor_ctrl_pkg::cmd_pend_t pend;
    sensor_ctrl_pkg::cmd_pend_t next_pend;
    sensor_ctrl_pkg::temp_cal_t cal;
    sensor_ctrl_pkg::temp_cal_t next_cal;
    logic                       reset_seen;
    logic                       next_reset_seen;
    logic [7:0]                 next_rdata;
    logic                       next_comm_allowed;
    logic                       next_retune_channel;
    logic                       sys_wr;

    // the stored config bits sit at bits 5..2, so shift down and keep four bits
    localparam sensor_ctrl_pkg::sys_cfg_t CFG_RESET =
        sensor_ctrl_pkg::sys_cfg_t'(4'(`SC_SYS_RESET >> `SC_BIT_WINDOW_SEL));
    localparam sensor_ctrl_pkg::temp_cal_t CAL_RESET = {`SC_CAL_RESET, `SC_CAL_RESET, `SC_CAL_RESET};

    // true when the reading has left the band around the tuning target
    function automatic logic outside_window(input logic [RD_W-1:0] rd, input logic [RD_W-1:0] tgt,
                                            input logic narrow);
        logic [RD_W-1:0] diff;
        logic [RD_W-1:0] band;
        diff = (rd > tgt) ? rd - tgt : tgt - rd;
        band = narrow ? (tgt >> `SC_WINDOW_NARROW_SHIFT) : (tgt >> `SC_WINDOW_WIDE_SHIFT);
        outside_window = diff > band;
    endfunction

    assign sys_wr = i_reg_wr && (i_reg_addr == `SC_ADDR_SYS_CTRL);

    // configuration and calibration; a finished watchdog reset restores every default
    always_comb begin
        next_cfg = cfg;
        next_cal = cal;
        if (i_watchdog_done && pend.soft_reset) begin
            next_cfg = CFG_RESET;
            next_cal = CAL_RESET;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `SC_ADDR_TEMP_MUL) begin
                next_cal.multiplier = i_reg_wdata;
            end else if (i_reg_addr == `SC_ADDR_TEMP_DIV) begin
                next_cal.divider = i_reg_wdata;
            end else if (i_reg_addr == `SC_ADDR_TEMP_OFF) begin
                next_cal.offset = i_reg_wdata;
            end else if (i_reg_addr == `SC_ADDR_SYS_CTRL) begin
                next_cfg.event_mode             = i_reg_wdata[`SC_BIT_EVENT_MODE];
                next_cfg.slow_oscillator_select = i_reg_wdata[`SC_BIT_SLOW_OSC];
                next_cfg.talk_during_tuning     = i_reg_wdata[`SC_BIT_TALK_TUNING];
                next_cfg.retune_window_select   = i_reg_wdata[`SC_BIT_WINDOW_SEL];
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cfg <= CFG_RESET;
            cal <= CAL_RESET;
        end else begin
            cfg <= next_cfg;
            cal <= next_cal;
        end
    end

    // set-only commands: a one arms, a zero does nothing, completion clears
    always_comb begin
        next_pend       = pend;
        next_reset_seen = reset_seen;
        if (sys_wr && i_reg_wdata[`SC_BIT_ACK_RESET]) begin
            next_reset_seen = 1'b0;
        end
        if (i_tuning_done) begin
            next_pend.retune_all = 1'b0;
        end
        if (i_refresh_done) begin
            next_pend.refresh_avg = 1'b0;
        end
        if (i_watchdog_done && pend.soft_reset) begin
            next_pend.soft_reset = 1'b0;
        end
        // arming after the clears so a new request in a completion cycle survives, except a retune or refresh request in a watchdog completion
        if (sys_wr) begin
            next_pend.soft_reset  = next_pend.soft_reset | i_reg_wdata[`SC_BIT_SOFT_RESET];
            next_pend.retune_all  = next_pend.retune_all | i_reg_wdata[`SC_BIT_RETUNE_ALL];
            next_pend.refresh_avg = next_pend.refresh_avg | i_reg_wdata[`SC_BIT_REFRESH_AVG];
        end
        // a watchdog reset drops other pending work and raises the event; set beats ack
        if (i_watchdog_done && pend.soft_reset) begin
            next_pend.retune_all  = 1'b0;
            next_pend.refresh_avg = 1'b0;
            next_reset_seen       = 1'b1;
        end
    end

    // reset_seen starts high so power-on reset is reported like any other
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pend       <= '0;
            reset_seen <= 1'b1;
        end else begin
            pend       <= next_pend;
            reset_seen <= next_reset_seen;
        end
    end

    // read data, communication gate and per-channel retune request
    always_comb begin
        next_rdata = o_reg_rdata;
        if (i_reg_rd) begin
            if (i_reg_addr == `SC_ADDR_TEMP_MUL) begin
                next_rdata = cal.multiplier;
            end else if (i_reg_addr == `SC_ADDR_TEMP_DIV) begin
                next_rdata = cal.divider;
            end else if (i_reg_addr == `SC_ADDR_TEMP_OFF) begin
                next_rdata = cal.offset;
            end else if (i_reg_addr == `SC_ADDR_SYS_CTRL) begin
                // acknowledge completes at once and so always reads zero
                next_rdata = {pend.soft_reset, 1'b0, cfg, pend.retune_all, pend.refresh_avg};
            end else begin
                next_rdata = `SC_READ_UNMAPPED;
            end
        end
        next_comm_allowed   = cfg.talk_during_tuning || !i_tuning_active;
        next_retune_channel = i_reading_valid &&
                              outside_window(i_reading, i_target, cfg.retune_window_select);
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata      <= `SC_READ_UNMAPPED;
            o_comm_allowed   <= 1'b1;
            o_retune_channel <= 1'b0;
        end else begin
            o_reg_rdata      <= next_rdata;
            o_comm_allowed   <= next_comm_allowed;
            o_retune_channel <= next_retune_channel;
        end
    end

    // outputs taken directly from their flip-flops
    assign o_watchdog_reset         = pend.soft_reset;
    assign o_retune_all             = pend.retune_all;
    assign o_refresh_all_avg        = pend.refresh_avg;
    assign o_reset_event            = reset_seen;
    assign o_event_mode             = cfg.event_mode;
    assign o_slow_oscillator_select = cfg.slow_oscillator_select;
    assign o_retune_window_select   = cfg.retune_window_select;

    // the retune request is issued as written; the host keeps it apart from an oscillator change
    temp_cal_unit #(
        .RAW_W (RAW_W)
    ) u_temp (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_raw        (i_temp_raw),
        .i_raw_valid  (i_temp_raw_valid),
        .i_cal        (cal),
        .o_temp       (o_temp),
        .o_temp_valid (o_temp_valid)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_sys_write_bit(int b);
        sys_wr && i_reg_wdata[b] && !i_watchdog_done;
    endsequence
    sequence s_wd_finish;
        o_watchdog_reset && i_watchdog_done && !(sys_wr && i_reg_wdata[`SC_BIT_SOFT_RESET]);
    endsequence

    a_soft_reset_arm: assert property (s_sys_write_bit(`SC_BIT_SOFT_RESET) |=> o_watchdog_reset)
        else $error("soft reset write did not request watchdog reset");
    a_soft_reset_done: assert property (s_wd_finish |=> !o_watchdog_reset && o_reset_event
        && !o_event_mode && !o_slow_oscillator_select && !o_retune_window_select
        && !o_retune_all && !o_refresh_all_avg)
        else $error("watchdog reset did not complete correctly");
    a_event_until_ack: assert property (o_reset_event && !(sys_wr && i_reg_wdata[`SC_BIT_ACK_RESET])
        |=> o_reset_event)
        else $error("reset event dropped without acknowledge");
    a_ack_clears: assert property (s_sys_write_bit(`SC_BIT_ACK_RESET) |=> !o_reset_event)
        else $error("acknowledge did not clear reset event");
    a_mode_bits: assert property (sys_wr && !i_watchdog_done |=>
        o_event_mode == $past(i_reg_wdata[`SC_BIT_EVENT_MODE])
        && o_slow_oscillator_select == $past(i_reg_wdata[`SC_BIT_SLOW_OSC]))
        else $error("mode bits not stored");
    a_comm_gate: assert property (i_tuning_active && !cfg.talk_during_tuning ##1 1'b1
        |-> !o_comm_allowed)
        else $error("communication allowed during tuning");
    a_window_check: assert property (i_reading_valid && cfg.retune_window_select
        && {1'b0, i_reading} > {1'b0, i_target} + (i_target >> `SC_WINDOW_NARROW_SHIFT)
        && i_reading >= i_target |=> o_retune_channel)
        else $error("reading outside narrow window not flagged");
    a_retune_hold: assert property (o_retune_all && !i_tuning_done && !i_watchdog_done
        |=> o_retune_all)
        else $error("retune request dropped before completion");
    a_refresh_done: assert property (o_refresh_all_avg && i_refresh_done
        && !(sys_wr && i_reg_wdata[`SC_BIT_REFRESH_AVG]) |=> !o_refresh_all_avg)
        else $error("refresh request not cleared on completion");
    a_zero_ignored: assert property (sys_wr && !i_reg_wdata[`SC_BIT_RETUNE_ALL] && !o_retune_all
        |=> !o_retune_all)
        else $error("zero write armed retune");

endmodule
`default_nettype wire

// File: hdl/temp_cal_unit.sv
// temperature calibration: scale a raw reading by multiplier, divider and offset
`default_nettype none
`include "sensor_ctrl_params.svh"
module temp_cal_unit #(
    parameter int RAW_W = 16
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    input  wire logic [RAW_W-1:0]            i_raw,
    input  wire logic                        i_raw_valid,
    input  wire sensor_ctrl_pkg::temp_cal_t  i_cal,
    output var  logic [RAW_W+9:0]            o_temp,
    output var  logic                        o_temp_valid
);
    localparam int RES_W = RAW_W + 10;

    logic [RES_W-1:0] next_temp;
    logic             next_valid;

    // stored value plus one, so a zero field means a factor of one
    function automatic logic [8:0] plus_one(input logic [7:0] v);
        plus_one = {1'b0, v} + 9'h001;
    endfunction

    // full computation; an all-ones field gives 256, which the host keeps clear of
    function automatic logic [RES_W-1:0] calc(input logic [RAW_W-1:0] raw, input sensor_ctrl_pkg::temp_cal_t c);
        logic [RES_W-1:0] prod;
        prod = RES_W'(raw) * RES_W'(plus_one(c.multiplier));
        calc = prod / RES_W'(plus_one(c.divider)) + RES_W'(c.offset);
    endfunction

    // result is latched one cycle after a valid raw sample
    always_comb begin
        next_valid = i_raw_valid;
        next_temp  = o_temp;
        if (i_raw_valid) begin
            next_temp = calc(i_raw, i_cal);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_temp       <= '0;
            o_temp_valid <= 1'b0;
        end else begin
            o_temp       <= next_temp;
            o_temp_valid <= next_valid;
        end
    end

    a_temp_value: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_raw_valid |=> o_temp_valid && o_temp == ($past(RES_W'(i_raw)) * ({1'b0, $past(i_cal.multiplier)} + 1))
            / ({1'b0, $past(i_cal.divider)} + 1) + $past(i_cal.offset))
        else $error("temperature result does not match calibration");

    a_temp_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_raw_valid |=> !o_temp_valid && $stable(o_temp))
        else $error("temperature result changed without a sample");

endmodule
`default_nettype wire
